/* File: llc_pkg.sv */
// Package for the link-layer configuration, cipher and RF test register slice.
// Assumes a 32-bit word register port where offsets are byte addresses.
package llc_pkg;
  // ---------------------------------------------------------------------------
  // Register byte offsets.
  // ---------------------------------------------------------------------------
  localparam logic [31:0] LLC_ADV_INTERVAL_OFS = 32'h400000A0; // Advertising spacing.
  localparam logic [31:0] LLC_SCAN_CNT_OFS = 32'h400000A4; // Active scan counters.
  localparam logic [31:0] LLC_PUB_PTR_OFS = 32'h400000B0; // Public list base.
  localparam logic [31:0] LLC_PRIV_PTR_OFS = 32'h400000B4; // Private list base.
  localparam logic [31:0] LLC_DEV_CNT_OFS = 32'h400000B8; // List entry counts.
  localparam logic [31:0] LLC_CIPHER_CTL_OFS = 32'h400000C0; // Cipher start.
  localparam logic [31:0] LLC_KEY0_OFS = 32'h400000C4; // Key bits 31:0.
  localparam logic [31:0] LLC_KEY1_OFS = 32'h400000C8; // Key bits 63:32.
  localparam logic [31:0] LLC_KEY2_OFS = 32'h400000CC; // Key bits 95:64.
  localparam logic [31:0] LLC_KEY3_OFS = 32'h400000D0; // Key bits 127:96.
  localparam logic [31:0] LLC_BLOCK_PTR_OFS = 32'h400000D4; // Cipher block base.
  localparam logic [31:0] LLC_TX_MIC_OFS = 32'h400000D8; // Send integrity code.
  localparam logic [31:0] LLC_RX_MIC_OFS = 32'h400000DC; // Receive integrity code.
  localparam logic [31:0] LLC_RF_TEST_OFS = 32'h400000E0; // RF test control.
  // ---------------------------------------------------------------------------
  // Field positions and widths.
  // ---------------------------------------------------------------------------
  localparam int LLC_ADV_W = 14; // Advertising interval width.
  localparam int LLC_SCAN_W = 9; // Scan counter width.
  localparam int LLC_SCAN_INIT_A_LSB = 16; // Back-off field low bit.
  localparam int LLC_PTR_W = 16; // Pointer width.
  localparam int LLC_CNT_W = 8; // Entry count width.
  localparam int LLC_PRIV_CNT_LSB = 8; // Private count low bit.
  localparam int LLC_START_BIT = 0; // Cipher start bit.
  localparam int LLC_ENDLESS_RX_BIT = 31; // Endless receive bit.
  localparam int LLC_ENDLESS_TX_BIT = 15; // Endless transmit bit.
  localparam int LLC_SIZE_SRC_BIT = 14; // Payload size source bit.
  localparam int LLC_PRBS_KIND_BIT = 13; // Pseudo-random kind bit.
  localparam int LLC_ORIGIN_BIT = 12; // Payload origin bit.
  localparam int LLC_LEN_W = 9; // Test payload length width.
  // ---------------------------------------------------------------------------
  // Generator seeds and reset value.
  // ---------------------------------------------------------------------------
  localparam logic [8:0] LLC_PRBS9_SEED = 9'h1FF; // All-ones 9-stage seed.
  localparam logic [14:0] LLC_PRBS15_SEED = 15'h7FFF; // All-ones 15-stage seed.
  localparam logic [31:0] LLC_ZERO = 32'h00000000; // Common reset value.
  // Cipher engine state.
  typedef enum logic [0:0] {LLC_IDLE, LLC_BUSY} llc_state_t;
endpackage

/* File: llc_regs.sv */
// Register slice of the link-layer controller: advertising, scan, white-list,
// cipher control with its engine handshake, and RF test payload generators.
// Assumes a synchronous single-cycle register port and an external cipher
// engine that raises a one-cycle done pulse with its integrity codes.
//
// Operation
// - Hold 14-bit advertising interval in microseconds.
// - Hold 9-bit back-off initial value.
// - Hold 9-bit active scan upper limit.
// - Hold public and private list pointers.
// - Hold private and public entry counts.
// - Writing one to start begins encryption.
// - Start clears when done event occurs.
// - Key assembled from four ascending words.
// - Hold 16-bit cipher block pointer.
// - Read-only integrity codes captured on done while busy.
// - Endless receive bit keeps window open.
// - Endless transmit bit gives endless payload.
// - Endless non-random payload repeats test length.
// - Size source picks descriptor or test length.
// - Kind bit picks 9 or 15 stage.
// - Nine-stage generator 1+x5+x9, seed ones.
// - Fifteen-stage generator given polynomial, seed ones.
// - Origin bit picks structure or generator payload.
// - Hold 9-bit test payload length.
// - Reset clears every field.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module llc_regs
  import llc_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic [31:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic I_CRYPT_DONE,
  input wire logic [31:0] I_TX_MIC,
  input wire logic [31:0] I_RX_MIC,
  input wire logic [LLC_LEN_W-1:0] I_DESC_PAYLOAD_SIZE,
  input wire logic I_PRBS_LOAD,
  input wire logic I_PRBS_STEP,
  output logic O_CIPHER_START,
  output logic O_CIPHER_BUSY,
  output logic [127:0] O_CIPHER_KEY,
  output logic [LLC_PTR_W-1:0] O_CIPHER_BLOCK_BASE,
  output logic [LLC_ADV_W-1:0] O_ADV_SPACING_US,
  output logic [LLC_SCAN_W-1:0] O_SCAN_INIT_A,
  output logic [LLC_SCAN_W-1:0] O_SCAN_UPPER_BOUND,
  output logic [LLC_PTR_W-1:0] O_PUBLIC_LIST_BASE,
  output logic [LLC_PTR_W-1:0] O_PRIVATE_LIST_BASE,
  output logic [LLC_CNT_W-1:0] O_PUBLIC_ENTRY_COUNT,
  output logic [LLC_CNT_W-1:0] O_PRIVATE_ENTRY_COUNT,
  output logic O_ENDLESS_RECEIVE,
  output logic O_ENDLESS_TRANSMIT,
  output logic O_PAYLOAD_ORIGIN,
  output logic O_PSEUDO_RANDOM_KIND,
  output logic [LLC_LEN_W-1:0] O_PAYLOAD_SIZE,
  output logic O_REPEAT_PATTERN,
  output logic O_PRBS_BIT
);

  // ---------------------------------------------------------------------------
  // State record.
  // ---------------------------------------------------------------------------
  // All state of the block in one packed record.
  typedef struct packed {
    logic [LLC_ADV_W-1:0] adv_spacing_us; // Advertising interval.
    logic [LLC_SCAN_W-1:0] scan_init_a; // Back-off initial value.
    logic [LLC_SCAN_W-1:0] scan_upper_bound; // Upper limit value.
    logic [LLC_PTR_W-1:0] public_list_base; // Public list pointer.
    logic [LLC_PTR_W-1:0] private_list_base; // Private list pointer.
    logic [LLC_CNT_W-1:0] public_entry_count; // Public entries.
    logic [LLC_CNT_W-1:0] private_entry_count; // Private entries.
    logic start; // Cipher start bit.
    logic start_pulse; // One-cycle start to the engine.
    llc_state_t state; // Engine tracking state.
    logic [127:0] key; // Cipher key.
    logic [LLC_PTR_W-1:0] cipher_block_base; // Block pointer.
    logic [31:0] send_integrity_code; // Transmit MIC.
    logic [31:0] recv_integrity_code; // Receive MIC.
    logic endless_receive; // Endless receive window.
    logic endless_transmit; // Endless transmit payload.
    logic payload_size_source; // Size source select.
    logic pseudo_random_kind; // Generator kind.
    logic payload_origin; // Payload origin select.
    logic [LLC_LEN_W-1:0] test_payload_bytes; // Test payload length.
    logic [8:0] prbs9; // Nine-stage shift register.
    logic [14:0] prbs15; // Fifteen-stage shift register.
    logic [31:0] rdata; // Read data stage.
    logic [LLC_LEN_W-1:0] payload_size; // Selected payload size.
    logic repeat_pattern; // Repeat-pattern indicator.
  } llc_regs_t;

  llc_regs_t st_q; // Registered state.
  llc_regs_t st_d; // Next state.

  // ---------------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------------
  // Handles writes, reads, engine handshake and the payload generators.
  always_comb begin
    logic fb9;
    logic fb15;
    fb9 = 1'b0;
    fb15 = 1'b0;
    st_d = st_q;
    st_d.start_pulse = 1'b0;
    st_d.rdata = LLC_ZERO;
    // Register writes; reserved bits are simply not stored.
    if (I_WR) begin
      if (I_ADDR == LLC_ADV_INTERVAL_OFS) begin
        st_d.adv_spacing_us = I_WDATA[LLC_ADV_W-1:0];
      end else if (I_ADDR == LLC_SCAN_CNT_OFS) begin
        st_d.scan_init_a = I_WDATA[LLC_SCAN_INIT_A_LSB +: LLC_SCAN_W];
        st_d.scan_upper_bound = I_WDATA[LLC_SCAN_W-1:0];
      end else if (I_ADDR == LLC_PUB_PTR_OFS) begin
        st_d.public_list_base = I_WDATA[LLC_PTR_W-1:0];
      end else if (I_ADDR == LLC_PRIV_PTR_OFS) begin
        st_d.private_list_base = I_WDATA[LLC_PTR_W-1:0];
      end else if (I_ADDR == LLC_DEV_CNT_OFS) begin
        st_d.private_entry_count = I_WDATA[LLC_PRIV_CNT_LSB +: LLC_CNT_W];
        st_d.public_entry_count = I_WDATA[LLC_CNT_W-1:0];
      end else if (I_ADDR == LLC_CIPHER_CTL_OFS) begin
        // Only a one starts; a zero is ignored, as is a one while running.
        if (I_WDATA[LLC_START_BIT] && st_q.state == LLC_IDLE) begin
          st_d.start = 1'b1;
          st_d.start_pulse = 1'b1;
        end
      end else if (I_ADDR == LLC_KEY0_OFS) begin
        st_d.key[31:0] = I_WDATA;
      end else if (I_ADDR == LLC_KEY1_OFS) begin
        st_d.key[63:32] = I_WDATA;
      end else if (I_ADDR == LLC_KEY2_OFS) begin
        st_d.key[95:64] = I_WDATA;
      end else if (I_ADDR == LLC_KEY3_OFS) begin
        st_d.key[127:96] = I_WDATA;
      end else if (I_ADDR == LLC_BLOCK_PTR_OFS) begin
        st_d.cipher_block_base = I_WDATA[LLC_PTR_W-1:0];
      end else if (I_ADDR == LLC_RF_TEST_OFS) begin
        st_d.endless_receive = I_WDATA[LLC_ENDLESS_RX_BIT];
        st_d.endless_transmit = I_WDATA[LLC_ENDLESS_TX_BIT];
        st_d.payload_size_source = I_WDATA[LLC_SIZE_SRC_BIT];
        st_d.pseudo_random_kind = I_WDATA[LLC_PRBS_KIND_BIT];
        st_d.payload_origin = I_WDATA[LLC_ORIGIN_BIT];
        st_d.test_payload_bytes = I_WDATA[LLC_LEN_W-1:0];
      end
    end
    // Engine tracking: the done event while busy ends the operation, clears start
    // and latches the integrity codes.
    case (st_q.state)
      LLC_IDLE: begin
        if (st_d.start_pulse) begin
          st_d.state = LLC_BUSY;
        end
      end
      LLC_BUSY: begin
        if (I_CRYPT_DONE) begin
          st_d.state = LLC_IDLE;
          st_d.start = 1'b0;
          st_d.send_integrity_code = I_TX_MIC;
          st_d.recv_integrity_code = I_RX_MIC;
        end
      end
      default: begin
        st_d.state = LLC_IDLE;
      end
    endcase
    // Register reads; unmapped offsets and reserved bits read zero.
    if (I_RD) begin
      if (I_ADDR == LLC_ADV_INTERVAL_OFS) begin
        st_d.rdata[LLC_ADV_W-1:0] = st_q.adv_spacing_us;
      end else if (I_ADDR == LLC_SCAN_CNT_OFS) begin
        st_d.rdata[LLC_SCAN_INIT_A_LSB +: LLC_SCAN_W] = st_q.scan_init_a;
        st_d.rdata[LLC_SCAN_W-1:0] = st_q.scan_upper_bound;
      end else if (I_ADDR == LLC_PUB_PTR_OFS) begin
        st_d.rdata[LLC_PTR_W-1:0] = st_q.public_list_base;
      end else if (I_ADDR == LLC_PRIV_PTR_OFS) begin
        st_d.rdata[LLC_PTR_W-1:0] = st_q.private_list_base;
      end else if (I_ADDR == LLC_DEV_CNT_OFS) begin
        st_d.rdata[LLC_PRIV_CNT_LSB +: LLC_CNT_W] = st_q.private_entry_count;
        st_d.rdata[LLC_CNT_W-1:0] = st_q.public_entry_count;
      end else if (I_ADDR == LLC_CIPHER_CTL_OFS) begin
        st_d.rdata[LLC_START_BIT] = st_q.start;
      end else if (I_ADDR == LLC_KEY0_OFS) begin
        st_d.rdata = st_q.key[31:0];
      end else if (I_ADDR == LLC_KEY1_OFS) begin
        st_d.rdata = st_q.key[63:32];
      end else if (I_ADDR == LLC_KEY2_OFS) begin
        st_d.rdata = st_q.key[95:64];
      end else if (I_ADDR == LLC_KEY3_OFS) begin
        st_d.rdata = st_q.key[127:96];
      end else if (I_ADDR == LLC_BLOCK_PTR_OFS) begin
        st_d.rdata[LLC_PTR_W-1:0] = st_q.cipher_block_base;
      end else if (I_ADDR == LLC_TX_MIC_OFS) begin
        st_d.rdata = st_q.send_integrity_code;
      end else if (I_ADDR == LLC_RX_MIC_OFS) begin
        st_d.rdata = st_q.recv_integrity_code;
      end else if (I_ADDR == LLC_RF_TEST_OFS) begin
        st_d.rdata[LLC_ENDLESS_RX_BIT] = st_q.endless_receive;
        st_d.rdata[LLC_ENDLESS_TX_BIT] = st_q.endless_transmit;
        st_d.rdata[LLC_SIZE_SRC_BIT] = st_q.payload_size_source;
        st_d.rdata[LLC_PRBS_KIND_BIT] = st_q.pseudo_random_kind;
        st_d.rdata[LLC_ORIGIN_BIT] = st_q.payload_origin;
        st_d.rdata[LLC_LEN_W-1:0] = st_q.test_payload_bytes;
      end
    end
    // Pseudo-random generators: load with all ones, then step on request.
    fb9 = st_q.prbs9[8] ^ st_q.prbs9[4];
    fb15 = st_q.prbs15[14] ^ st_q.prbs15[13] ^ st_q.prbs15[12]
           ^ st_q.prbs15[1] ^ st_q.prbs15[0];
    if (I_PRBS_LOAD) begin
      st_d.prbs9 = LLC_PRBS9_SEED;
      st_d.prbs15 = LLC_PRBS15_SEED;
    end else if (I_PRBS_STEP) begin
      st_d.prbs9 = {st_q.prbs9[7:0], fb9};
      st_d.prbs15 = {st_q.prbs15[13:0], fb15};
    end
    // Payload size selection for the packet controller.
    if (st_q.payload_size_source) begin
      st_d.payload_size = st_q.test_payload_bytes;
    end else begin
      st_d.payload_size = I_DESC_PAYLOAD_SIZE;
    end
    // Endless payload without the generator repeats the test-length pattern.
    st_d.repeat_pattern = st_q.endless_transmit & ~st_q.payload_origin;
  end

  // ---------------------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------------------
  // Asynchronous reset clears every field to zero.
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs from the state register, all direct except the generator bit.
  // ---------------------------------------------------------------------------
  assign O_RDATA = st_q.rdata;
  assign O_CIPHER_START = st_q.start_pulse;
  assign O_CIPHER_BUSY = st_q.start;
  assign O_CIPHER_KEY = st_q.key;
  assign O_CIPHER_BLOCK_BASE = st_q.cipher_block_base;
  assign O_ADV_SPACING_US = st_q.adv_spacing_us;
  assign O_SCAN_INIT_A = st_q.scan_init_a;
  assign O_SCAN_UPPER_BOUND = st_q.scan_upper_bound;
  assign O_PUBLIC_LIST_BASE = st_q.public_list_base;
  assign O_PRIVATE_LIST_BASE = st_q.private_list_base;
  assign O_PUBLIC_ENTRY_COUNT = st_q.public_entry_count;
  assign O_PRIVATE_ENTRY_COUNT = st_q.private_entry_count;
  assign O_ENDLESS_RECEIVE = st_q.endless_receive;
  assign O_ENDLESS_TRANSMIT = st_q.endless_transmit;
  assign O_PAYLOAD_ORIGIN = st_q.payload_origin;
  assign O_PSEUDO_RANDOM_KIND = st_q.pseudo_random_kind;
  assign O_PAYLOAD_SIZE = st_q.payload_size;
  assign O_REPEAT_PATTERN = st_q.repeat_pattern;
  // Generator output picked by the kind bit.
  assign O_PRBS_BIT = st_q.pseudo_random_kind ? st_q.prbs15[14] : st_q.prbs9[8];

endmodule

/* File: llc_regs_assertions.sv */
// Checker of the link-layer register slice, bound onto the ports of its top module.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/10ps
module llc_regs_checker
  import llc_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic [31:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic I_CRYPT_DONE,
  input wire logic [31:0] I_TX_MIC,
  input wire logic I_PRBS_LOAD,
  input wire logic O_CIPHER_START,
  input wire logic O_CIPHER_BUSY,
  input wire logic [127:0] O_CIPHER_KEY,
  input wire logic [LLC_ADV_W-1:0] O_ADV_SPACING_US,
  input wire logic O_ENDLESS_TRANSMIT,
  input wire logic O_PAYLOAD_ORIGIN,
  input wire logic O_REPEAT_PATTERN,
  input wire logic O_PRBS_BIT
);
  // ---------------------------------------------------------------------------
  // Port relations, all in the single clock domain.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  // An accepted start write gives exactly one start pulse and raises busy.
  property p_start;
    I_WR && I_ADDR == LLC_CIPHER_CTL_OFS && I_WDATA[0] && !O_CIPHER_BUSY
      |=> O_CIPHER_START && O_CIPHER_BUSY ##1 !O_CIPHER_START;
  endproperty
  a_start: assert property (p_start) else $error("start write not taken");
  // A start write while the engine runs gives no second start pulse.
  property p_refuse;
    I_WR && I_ADDR == LLC_CIPHER_CTL_OFS && O_CIPHER_BUSY |=> !O_CIPHER_START;
  endproperty
  a_refuse: assert property (p_refuse) else $error("start taken while busy");
  // The done event ends the operation in the next cycle.
  property p_done;
    O_CIPHER_BUSY && I_CRYPT_DONE |=> !O_CIPHER_BUSY;
  endproperty
  a_done: assert property (p_done) else $error("busy not cleared by done");
  // A read right after done returns the captured send integrity code.
  property p_mic;
    (O_CIPHER_BUSY && I_CRYPT_DONE) ##1 (I_RD && I_ADDR == LLC_TX_MIC_OFS)
      |=> O_RDATA == $past(I_TX_MIC, 2);
  endproperty
  a_mic: assert property (p_mic) else $error("integrity code not captured");
  // Read data is zero outside the cycle after a read.
  property p_idle;
    !I_RD |=> O_RDATA == LLC_ZERO;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  // The top key word lands in the top quarter of the key.
  property p_key;
    I_WR && I_ADDR == LLC_KEY3_OFS |=> O_CIPHER_KEY[127:96] == $past(I_WDATA);
  endproperty
  a_key: assert property (p_key) else $error("key word misplaced");
  // The advertising spacing follows its write.
  property p_adv;
    I_WR && I_ADDR == LLC_ADV_INTERVAL_OFS |=> O_ADV_SPACING_US == $past(I_WDATA[13:0]);
  endproperty
  a_adv: assert property (p_adv) else $error("spacing not written");
  // Pattern repeat follows endless transmit without generator payload.
  property p_rep;
    1'b1 |=> O_REPEAT_PATTERN == $past(O_ENDLESS_TRANSMIT && !O_PAYLOAD_ORIGIN);
  endproperty
  a_rep: assert property (p_rep) else $error("repeat flag wrong");
  // A load seeds the generators with ones, so the output bit is one.
  property p_load;
    I_PRBS_LOAD |=> O_PRBS_BIT;
  endproperty
  a_load: assert property (p_load) else $error("generator not seeded");
endmodule

/* File: llc_regs_tb_top.sv */
// Self-checking bench of the link-layer register slice with random register traffic.
// Assumes the package and the checker file are compiled before it.
`timescale 1ns/10ps
module llc_regs_tb_top
  import llc_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Stimulus, observed ports and bookkeeping.
  // ---------------------------------------------------------------------------
  logic clk, rstn, wr, rd, done, load, step, start, busy, rep, pbit, erx, etx, orig, kind;
  logic [31:0] addr, wdata, tx_mic, rx_mic, rdata, seed, d;
  logic [127:0] key;
  logic [15:0] blk, pub, priv;
  logic [13:0] adv;
  logic [8:0] desc, sinit, supper, psize, s9;
  logic [7:0] pubc, privc;
  logic [14:0] s15;
  logic [31:0] ex [11];
  logic [31:0] ofs [11] = '{32'h400000A0, 32'h400000A4, 32'h400000B0, 32'h400000B4,
    32'h400000B8, 32'h400000C4, 32'h400000C8, 32'h400000CC, 32'h400000D0, 32'h400000D4,
    32'h400000E0};
  logic [31:0] msk [11] = '{32'h00003FFF, 32'h01FF01FF, 32'h0000FFFF, 32'h0000FFFF,
    32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0000FFFF,
    32'h8000F1FF};
  int error_cnt, checks;
  llc_regs i_llc_regs (.I_REF_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CRYPT_DONE(done), .I_TX_MIC(tx_mic),
    .I_RX_MIC(rx_mic), .I_DESC_PAYLOAD_SIZE(desc), .I_PRBS_LOAD(load), .I_PRBS_STEP(step),
    .O_CIPHER_START(start), .O_CIPHER_BUSY(busy), .O_CIPHER_KEY(key),
    .O_CIPHER_BLOCK_BASE(blk), .O_ADV_SPACING_US(adv), .O_SCAN_INIT_A(sinit),
    .O_SCAN_UPPER_BOUND(supper), .O_PUBLIC_LIST_BASE(pub), .O_PRIVATE_LIST_BASE(priv),
    .O_PUBLIC_ENTRY_COUNT(pubc), .O_PRIVATE_ENTRY_COUNT(privc), .O_ENDLESS_RECEIVE(erx),
    .O_ENDLESS_TRANSMIT(etx), .O_PAYLOAD_ORIGIN(orig), .O_PSEUDO_RANDOM_KIND(kind),
    .O_PAYLOAD_SIZE(psize), .O_REPEAT_PATTERN(rep), .O_PRBS_BIT(pbit));
  // Advances the bench's random source and returns its new value.
  function automatic logic [31:0] rnd();
    seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
    return seed;
  endfunction
  // Compares one result and counts it.
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One-cycle register write.
  task automatic wrr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle register read, data checked in the following cycle.
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // One-cycle done event carrying integrity codes.
  task automatic pulse_done(input logic [31:0] v);
    @(posedge clk);
    done <= 1'b1;
    tx_mic <= v;
    rx_mic <= ~v;
    @(posedge clk);
    done <= 1'b0;
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Clock, watchdog and test sequence.
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    {rstn, wr, rd, done, load, step, addr, wdata, tx_mic, rx_mic, desc} = '0;
    seed = 32'hF414;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 11; i++) rdc(ofs[i], LLC_ZERO);
    rdc(LLC_CIPHER_CTL_OFS, LLC_ZERO);
    rdc(LLC_TX_MIC_OFS, LLC_ZERO);
    $display("test reset done");
    repeat (3) begin
      for (int i = 0; i < 11; i++) begin
        ex[i] = rnd() & msk[i];
        wrr(ofs[i], seed);
        rdc(ofs[i], ex[i]);
      end
    end
    chk(key, {ex[8], ex[7], ex[6], ex[5]});
    chk({adv, sinit, supper, blk}, {ex[0][13:0], ex[1][24:16], ex[1][8:0], ex[9][15:0]});
    chk({pub, priv, pubc, privc}, {ex[2][15:0], ex[3][15:0], ex[4][7:0], ex[4][15:8]});
    wrr(LLC_TX_MIC_OFS, rnd());
    rdc(LLC_TX_MIC_OFS, LLC_ZERO);
    rdc(32'h400000A8, LLC_ZERO);
    $display("test registers done");
    wrr(LLC_CIPHER_CTL_OFS, 32'hFFFFFFFE);
    rdc(LLC_CIPHER_CTL_OFS, LLC_ZERO);
    wrr(LLC_CIPHER_CTL_OFS, 32'h00000001);
    #1 chk({start, busy}, 2'b11);
    rdc(LLC_CIPHER_CTL_OFS, 32'h00000001);
    wrr(LLC_CIPHER_CTL_OFS, 32'h00000001);
    #1 chk({start, busy}, 2'b01);
    d = rnd();
    pulse_done(d);
    rd <= 1'b1;
    addr <= LLC_TX_MIC_OFS;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({busy, rdata}, {1'b0, d});
    rdc(LLC_RX_MIC_OFS, ~d);
    rdc(LLC_CIPHER_CTL_OFS, LLC_ZERO);
    pulse_done(~d);
    rdc(LLC_TX_MIC_OFS, d);
    $display("test cipher done");
    for (int k = 0; k < 2; k++) begin
      wrr(LLC_RF_TEST_OFS, {18'h0, k[0], 13'h0});
      @(posedge clk);
      load <= 1'b1;
      s9 = LLC_PRBS9_SEED;
      s15 = LLC_PRBS15_SEED;
      @(posedge clk);
      load <= 1'b0;
      repeat (60) begin
        d = rnd();
        step <= d[0];
        #1 chk(pbit, k[0] ? s15[14] : s9[8]);
        @(posedge clk);
        if (d[0]) begin
          s9 = {s9[7:0], s9[8] ^ s9[4]};
          s15 = {s15[13:0], s15[14] ^ s15[13] ^ s15[12] ^ s15[1] ^ s15[0]};
        end
      end
      step <= 1'b0;
    end
    $display("test generators done");
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      @(posedge clk);
      desc <= d[24:16];
      wrr(LLC_RF_TEST_OFS, {i[0], 15'h0, i[1], i[2], 1'b0, i[3], 3'h0, d[8:0]});
      @(posedge clk);
      #1 chk({erx, etx, orig, kind}, {i[0], i[1], i[3], 1'b0});
      chk(psize, i[2] ? d[8:0] : d[24:16]);
      chk(rep, i[1] & ~i[3]);
    end
    $display("test modes done");
    give_verdict();
  end
endmodule
bind llc_regs llc_regs_checker i_llc_regs_checker (.I_REF_CLK, .I_RSTN, .I_ADDR, .I_WDATA,
  .I_WR, .I_RD, .O_RDATA, .I_CRYPT_DONE, .I_TX_MIC, .I_PRBS_LOAD, .O_CIPHER_START,
  .O_CIPHER_BUSY, .O_CIPHER_KEY, .O_ADV_SPACING_US, .O_ENDLESS_TRANSMIT, .O_PAYLOAD_ORIGIN,
  .O_REPEAT_PATTERN, .O_PRBS_BIT);
